// File: include/spf_pkg.sv
// Shared constants and types for the serial port format and receive length block
package spf_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0  = 8'h00;
    localparam logic [7:0] OFS_RXLEN  = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_DATA   = 8'h60;
    // Control word, enable and length register fields
    localparam int DIR_LSB  = 8;
    localparam int IDLE_BIT = 7;
    localparam int EDGE_BIT = 6;
    localparam int FMT_LSB  = 4;
    localparam int ENA_BIT  = 0;
    localparam int FCNT_W   = 16;
    // Status fields
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_AVAIL_BIT = 1;
    localparam int ST_FULL_BIT  = 2;
    localparam int ST_REM_LSB   = 16;
    // Frame format codes
    localparam logic [1:0] FMT_SPI  = 2'h0;
    localparam logic [1:0] FMT_SSF  = 2'h1;
    localparam logic [1:0] FMT_CTRL = 2'h2;
    // Transfer direction codes
    localparam logic [1:0] DIR_TXRX = 2'h0;
    localparam logic [1:0] DIR_TX   = 2'h1;
    localparam logic [1:0] DIR_RX   = 2'h2;
    localparam logic [1:0] DIR_MEMRD = 2'h3;
    // Frame geometry
    localparam int FRAME_BITS = 8;
    localparam int BIT_CNT_W  = 4;
    localparam int EDGE_W     = 5;
    localparam logic [EDGE_W-1:0] LAST_EDGE = EDGE_W'(2 * FRAME_BITS - 1);
    localparam logic [BIT_CNT_W-1:0] FULL_BITS = BIT_CNT_W'(FRAME_BITS);
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCLK_HALF_NS  = 160;
    localparam int HALF_CYC      = (SCLK_HALF_NS / CLK_PERIOD_NS < 1) ? 1
                                   : SCLK_HALF_NS / CLK_PERIOD_NS;
    localparam int DIV_W         = 4;
    localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYC - 1);
    // Master sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LEAD = 4'b0010,
        ST_RUN  = 4'b0100,
        ST_STOP = 4'b1000
    } spf_state_t;
endpackage

// File: hw/spf_sync.sv
// Two-stage synchroniser for pin inputs
module spf_sync #(
    parameter int W = 1
) (
    // Clock and control
    input  wire logic         mclk_in,
    input  wire logic         rst_b_in,
    input  wire logic         ce_in,
    // Data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } spf_sync_t;

    spf_sync_t s;
    spf_sync_t next_s;

    always_comb begin
        next_s      = s;
        next_s.meta = d_in;
        next_s.sync = s.meta;
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign q_out = s.sync;
endmodule

// File: hw/spf_fifo.sv
// Receive word FIFO with valid and ready on both sides
module spf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and control
    input  wire logic             mclk_in,
    input  wire logic             rst_b_in,
    input  wire logic             ce_in,
    input  wire logic             flush_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } spf_fifo_t;

    spf_fifo_t        s;
    spf_fifo_t        next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready_out  = (s.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (s.cnt != '0);
    assign out_data_out  = mem[s.rp];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        next_s = s;
        if (flush_in) begin
            next_s = '0;
        end else begin
            if (push) begin
                next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
            end
            if (pop) begin
                next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
            end
            next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (ce_in && push && !flush_in) begin
            mem[s.wp] <= in_data_in;
        end
    end
endmodule

// File: hw/spf_port.sv
// Serial port format control, receive length and transfer engine
//
// Operation
// [R1] Master holds clock at idle level between transfers
// [R2] Fixed option: idle level and edge read defaults
// [R3] Edge bit 0: capture on first clock edge
// [R4] Edge bit 1: toggle one cycle later, second edge
// [R5] Two-bit format field picks one of three protocols
// [R6] Idle level and edge used only in SPI format
// [R7] Slave build: length register reads zero, ignores writes
// [R8] Receive directions use sixteen-bit frame count
// [R9] Master receives count plus one frames then stops
// [R10] Slave receive runs while it stays selected
// [R11] Reserved bits read zero and ignore writes
// [R12] Direction codes: both, transmit, receive, memory read
// [R13] Locked fields written only while controller disabled
// [R14] Down-counter loaded at start, stop at zero
// [R15] Registers reset to zero
//
// Decided for this implementation: the plain strobed port.
module spf_port #(
    parameter bit IS_MASTER    = 1'b1,
    parameter bit FIXED_FORMAT = 1'b0,
    parameter bit DEFAULT_IDLE = 1'b0,
    parameter bit DEFAULT_EDGE = 1'b0,
    parameter int FIFO_DEPTH   = 32
) (
    // Clock, reset, enable
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    input  wire logic        ce_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output logic      [31:0] rd_data_out,
    // Serial link
    input  wire logic        sclk_in,
    input  wire logic        ss_n_in,
    input  wire logic        rxd_in,
    output logic             sclk_out,
    output logic             ss_n_out,
    output logic             txd_out
);
    localparam int FB = spf_pkg::FRAME_BITS;

    typedef struct packed {
        logic                            en;
        logic [1:0]                      dir;
        logic [1:0]                      fmt;
        logic                            cpol;
        logic                            cpha;
        logic [spf_pkg::FCNT_W-1:0]      fcount;
        spf_pkg::spf_state_t             st;
        logic [spf_pkg::FCNT_W-1:0]      remain;
        logic                            ctl_phase;
        logic [spf_pkg::DIV_W-1:0]       div;
        logic [spf_pkg::EDGE_W-1:0]      edge_cnt;
        logic [spf_pkg::BIT_CNT_W-1:0]   bits;
        logic [FB-1:0]                   tx_word;
        logic [FB-1:0]                   tx_sh;
        logic [FB-1:0]                   rx_sh;
        logic                            sclk;
        logic                            ss_n;
        logic                            sclk_d;
        logic                            push;
        logic [FB-1:0]                   push_data;
        logic [31:0]                     rd_data;
    } spf_port_t;

    spf_port_t     s;
    spf_port_t     next_s;
    logic [2:0]    pins_s;
    logic          sclk_s;
    logic          ss_n_s;
    logic          rxd_s;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic [FB-1:0] fifo_out_data;
    logic          fifo_pop;
    logic          cpol_rd;
    logic          cpha_rd;
    logic          cpol_eff;
    logic          cpha_eff;
    logic          stall;
    logic          tick;
    logic          do_edge;
    logic          lead;
    logic          sample;
    logic          keep_rx;
    logic          start;

    // Pins come from another clock; all three pass two flops
    spf_sync #(
        .W(3)
    ) u_sync (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .d_in     ({sclk_in, ss_n_in, rxd_in}),
        .q_out    (pins_s)
    );
    assign sclk_s = pins_s[2];
    assign ss_n_s = pins_s[1];
    assign rxd_s  = pins_s[0];

    spf_fifo #(
        .WIDTH(FB),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_in       (mclk_in),
        .rst_b_in      (rst_b_in),
        .ce_in         (ce_in),
        .flush_in      (!s.en),
        .in_valid_in   (s.push),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (s.push_data),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_out_data)
    );

    assign fifo_pop = rd_en_in && (addr_in == spf_pkg::OFS_DATA);
    assign cpol_rd  = FIXED_FORMAT ? DEFAULT_IDLE : s.cpol; // R2
    assign cpha_rd  = FIXED_FORMAT ? DEFAULT_EDGE : s.cpha; // R2
    // Other formats run with the low-idle, first-edge timing
    assign cpol_eff = (s.fmt == spf_pkg::FMT_SPI) ? cpol_rd : 1'b0; // R6
    assign cpha_eff = (s.fmt == spf_pkg::FMT_SPI) ? cpha_rd : 1'b0; // R6
    assign keep_rx  = (s.dir != spf_pkg::DIR_TX) && !s.ctl_phase; // R12
    // A full FIFO holds the master clock; a slave cannot stall and drops
    assign stall    = s.push && !fifo_in_ready;
    assign tick     = (s.div == spf_pkg::HALF_LAST) && !stall;
    assign start    = IS_MASTER && s.en && wr_en_in && (addr_in == spf_pkg::OFS_DATA)
                      && (s.st == spf_pkg::ST_IDLE);

    always_comb begin
        do_edge = 1'b0;
        lead    = 1'b0;
        if (IS_MASTER) begin
            do_edge = tick && ((s.st == spf_pkg::ST_LEAD) || (s.st == spf_pkg::ST_RUN));
            lead    = !s.edge_cnt[0];
        end else begin
            do_edge = !ss_n_s && (sclk_s != s.sclk_d); // R10
            lead    = (sclk_s != cpol_eff);
        end
        sample = (lead != cpha_eff); // R3 R4
    end

    always_comb begin
        next_s = s;
        next_s.sclk_d = sclk_s;
        if (s.push && fifo_in_ready) begin
            next_s.push = 1'b0;
        end
        // Register writes
        if (wr_en_in) begin
            case (addr_in)
                spf_pkg::OFS_CTRL0: begin
                    next_s.fmt = wr_data_in[spf_pkg::FMT_LSB +: 2]; // R5
                    if (!s.en) begin // R13
                        next_s.dir = wr_data_in[spf_pkg::DIR_LSB +: 2];
                        if (!FIXED_FORMAT) begin // R2
                            next_s.cpol = wr_data_in[spf_pkg::IDLE_BIT];
                            next_s.cpha = wr_data_in[spf_pkg::EDGE_BIT];
                        end
                    end
                end
                spf_pkg::OFS_RXLEN: begin
                    if (IS_MASTER && !s.en) begin // R7 R13
                        next_s.fcount = wr_data_in[spf_pkg::FCNT_W-1:0]; // R8 R11
                    end
                end
                spf_pkg::OFS_ENABLE: begin
                    next_s.en = wr_data_in[spf_pkg::ENA_BIT];
                end
                spf_pkg::OFS_DATA: begin
                    next_s.tx_word = wr_data_in[FB-1:0];
                    if (s.st == spf_pkg::ST_IDLE) begin
                        next_s.tx_sh = wr_data_in[FB-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Register reads, answered one cycle later
        next_s.rd_data = '0;
        if (rd_en_in) begin
            case (addr_in)
                spf_pkg::OFS_CTRL0: begin
                    next_s.rd_data[spf_pkg::DIR_LSB +: 2] = s.dir;
                    next_s.rd_data[spf_pkg::IDLE_BIT]     = cpol_rd;
                    next_s.rd_data[spf_pkg::EDGE_BIT]     = cpha_rd;
                    next_s.rd_data[spf_pkg::FMT_LSB +: 2] = s.fmt;
                end
                spf_pkg::OFS_RXLEN: begin
                    if (IS_MASTER) begin // R7
                        next_s.rd_data[spf_pkg::FCNT_W-1:0] = s.fcount; // R11
                    end
                end
                spf_pkg::OFS_ENABLE: begin
                    next_s.rd_data[spf_pkg::ENA_BIT] = s.en;
                end
                spf_pkg::OFS_STATUS: begin
                    next_s.rd_data[spf_pkg::ST_BUSY_BIT]  = (s.st != spf_pkg::ST_IDLE)
                                                            || (!IS_MASTER && !ss_n_s);
                    next_s.rd_data[spf_pkg::ST_AVAIL_BIT] = fifo_out_valid;
                    next_s.rd_data[spf_pkg::ST_FULL_BIT]  = !fifo_in_ready;
                    next_s.rd_data[spf_pkg::ST_REM_LSB +: spf_pkg::FCNT_W] = s.remain;
                end
                spf_pkg::OFS_DATA: begin
                    if (fifo_out_valid) begin
                        next_s.rd_data[FB-1:0] = fifo_out_data;
                    end
                end
                default: begin
                end
            endcase
        end
        // Clock divider runs only while a transfer is out
        if (s.st == spf_pkg::ST_IDLE || stall) begin
            next_s.div = (s.st == spf_pkg::ST_IDLE) ? '0 : s.div;
        end else begin
            next_s.div = (s.div == spf_pkg::HALF_LAST) ? '0 : s.div + 1'b1;
        end
        // Shared edge handling for both ends
        if (do_edge) begin
            if (sample) begin
                next_s.rx_sh = {s.rx_sh[FB-2:0], rxd_s};
                next_s.bits  = s.bits + 1'b1;
            end else if (s.bits != '0) begin
                next_s.tx_sh = {s.tx_sh[FB-2:0], 1'b0};
            end
        end
        if (IS_MASTER) begin
            case (s.st)
                spf_pkg::ST_IDLE: begin
                    next_s.sclk = cpol_eff; // R1
                    next_s.ss_n = 1'b1;
                    if (start) begin
                        next_s.st        = spf_pkg::ST_LEAD;
                        next_s.ss_n      = 1'b0;
                        next_s.edge_cnt  = '0;
                        next_s.bits      = '0;
                        next_s.ctl_phase = (s.dir == spf_pkg::DIR_MEMRD); // R12
                        // Only receive-type transfers run past one frame
                        if (s.dir == spf_pkg::DIR_RX || s.dir == spf_pkg::DIR_MEMRD) begin
                            next_s.remain = s.fcount; // R8 R14
                        end else begin
                            next_s.remain = '0;
                        end
                    end
                end
                spf_pkg::ST_LEAD, spf_pkg::ST_RUN: begin
                    if (do_edge) begin
                        next_s.st       = spf_pkg::ST_RUN;
                        next_s.sclk     = !s.sclk; // R3 R4
                        next_s.edge_cnt = s.edge_cnt + 1'b1;
                        if (s.edge_cnt == spf_pkg::LAST_EDGE) begin
                            next_s.edge_cnt  = '0;
                            next_s.bits      = '0;
                            next_s.tx_sh     = s.tx_word;
                            next_s.push      = keep_rx;
                            next_s.push_data = next_s.rx_sh;
                            if (s.ctl_phase) begin
                                next_s.ctl_phase = 1'b0;
                            end else if (s.remain == '0) begin
                                next_s.st = spf_pkg::ST_STOP; // R9 R14
                            end else begin
                                next_s.remain = s.remain - 1'b1; // R14
                            end
                        end
                    end
                end
                spf_pkg::ST_STOP: begin
                    if (tick) begin
                        next_s.st   = spf_pkg::ST_IDLE;
                        next_s.ss_n = 1'b1; // R14
                    end
                end
                default: begin
                    next_s.st = spf_pkg::ST_IDLE;
                end
            endcase
        end else begin
            // Slave: no frame limit, deselect resets the frame
            if (ss_n_s) begin // R10
                next_s.bits  = '0;
                next_s.tx_sh = s.tx_word;
            end else if (do_edge && sample && s.bits == spf_pkg::FULL_BITS - 1'b1) begin
                next_s.bits      = '0;
                next_s.tx_sh     = s.tx_word;
                next_s.push      = (s.dir != spf_pkg::DIR_TX);
                next_s.push_data = next_s.rx_sh;
            end
        end
        // Disable ends a master transfer and drops a pending push at once
        if (!s.en) begin
            next_s.st   = spf_pkg::ST_IDLE;
            next_s.ss_n = 1'b1;
            next_s.push = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s      <= '0; // R15
            s.st   <= spf_pkg::ST_IDLE;
            s.ss_n <= 1'b1;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign rd_data_out = s.rd_data;
    assign sclk_out    = s.sclk;
    assign ss_n_out    = s.ss_n;
    assign txd_out     = s.tx_sh[FB-1];

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in || !ce_in);

    sequence lead_edge_s;
        // A disable in mid-frame aborts, so only enabled edges count
        IS_MASTER && s.en && s.st == spf_pkg::ST_LEAD && do_edge;
    endsequence
    sequence frame_last_s;
        IS_MASTER && s.en && s.st == spf_pkg::ST_RUN && do_edge
            && s.edge_cnt == spf_pkg::LAST_EDGE;
    endsequence

    idle_clock_a: assert property (IS_MASTER && s.st == spf_pkg::ST_IDLE && !start // R1
        |=> sclk_out == $past(cpol_eff)) else $error("idle clock level wrong");
    fixed_read_a: assert property (FIXED_FORMAT && rd_en_in && addr_in == spf_pkg::OFS_CTRL0 // R2
        |=> rd_data_out[spf_pkg::IDLE_BIT] == DEFAULT_IDLE
            && rd_data_out[spf_pkg::EDGE_BIT] == DEFAULT_EDGE) else $error("fixed bits wrong");
    first_edge_a: assert property (lead_edge_s and !cpha_eff // R3
        |=> s.bits == 1 && sclk_out != $past(sclk_out)) else $error("no first edge capture");
    second_edge_a: assert property (lead_edge_s and cpha_eff // R4
        |=> s.bits == 0 ##[1:8] s.bits == 1) else $error("capture not on second edge");
    format_field_a: assert property (wr_en_in && addr_in == spf_pkg::OFS_CTRL0 // R5
        |=> s.fmt == $past(wr_data_in[spf_pkg::FMT_LSB +: 2])) else $error("format lost");
    other_format_a: assert property (s.fmt != spf_pkg::FMT_SPI |-> !cpha_eff && !cpol_eff) // R6
        else $error("polarity used outside SPI");
    slave_len_a: assert property (!IS_MASTER && rd_en_in && addr_in == spf_pkg::OFS_RXLEN // R7
        |=> rd_data_out == '0) else $error("slave length not zero");
    count_load_a: assert property (start && s.dir == spf_pkg::DIR_RX // R8
        |=> s.remain == $past(s.fcount) && s.st == spf_pkg::ST_LEAD)
        else $error("count not loaded");
    end_xfer_a: assert property (frame_last_s and s.remain == '0 and !s.ctl_phase // R9
        |=> s.st == spf_pkg::ST_STOP ##[1:8] ss_n_out) else $error("transfer did not end");
    reserved_zero_a: assert property (rd_en_in && addr_in == spf_pkg::OFS_RXLEN // R11
        |=> rd_data_out[31:spf_pkg::FCNT_W] == '0) else $error("reserved bits set");
    lock_len_a: assert property (s.en && wr_en_in && addr_in == spf_pkg::OFS_RXLEN // R13
        |=> $stable(s.fcount)) else $error("locked count written");
endmodule

// File: dv/spf_peer.sv
// Serial slave model that feeds numbered bytes to the master
module spf_peer (
    // Clock and sample edge mode
    input  wire logic mclk_in,
    input  wire logic edge_in,
    // Link
    input  wire logic sclk_in,
    input  wire logic ss_n_in,
    output logic      rxd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int         edges = 0;
    int         g;
    logic       prev = 1'b0;
    logic [7:0] byte_v;
    initial rxd_out = 1'b0;
    always @(posedge mclk_in) begin
        prev <= sclk_in;
        if (ss_n_in) begin
            // Released line toggles so a stale bit never passes as data
            edges <= 0;
            rxd_out <= ~rxd_out;
        end else begin
            g = edges + int'(sclk_in != prev);
            edges <= g;
            // Shift on the edge that is not the sample edge
            g = (g > int'(edge_in)) ? g - int'(edge_in) : 0;
            byte_v = 8'hC3 ^ 8'(g / 16);
            rxd_out <= byte_v[7 - (g % 16) / 2];
        end
    end
endmodule

// File: dv/spf_port_test.sv
// Register and receive transfer tests of the serial port block
module spf_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic        edge_sel = 1'b0;
    logic [31:0] rdata;
    logic        sclk, ss_n, txd, rxd;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          n;

    spf_port i_spf_port (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
        .addr_in(addr), .wr_data_in(wd), .wr_en_in(we), .rd_en_in(re),
        .rd_data_out(rdata), .sclk_in(1'b0), .ss_n_in(1'b1), .rxd_in(rxd),
        .sclk_out(sclk), .ss_n_out(ss_n), .txd_out(txd));
    spf_peer i_spf_peer (.mclk_in(mclk_in), .edge_in(edge_sel),
        .sclk_in(sclk), .ss_n_in(ss_n), .rxd_out(rxd));

    always #20 mclk_in = ~mclk_in;

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Run is well under two thousand cycles; the ceiling leaves wide margin
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge mclk_in);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_in);
        addr <= a;
        re <= 1'b1;
        @(posedge mclk_in);
        re <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic xfer(input logic idle, input logic edg, input logic [1:0] dir);
        logic [31:0] ctl;
        logic [31:0] m;
        logic        prv;
        ctl = {22'h0, dir, idle, edg, 6'h0};
        // Memory read spends one unstored control frame first
        m = 32'(dir == spf_pkg::DIR_MEMRD);
        edge_sel <= edg;
        wr(8'h00, ctl);
        wr(8'h04, 32'h0000_0002);
        wr(8'h08, 32'h0000_0001);
        wr(8'h04, 32'h0000_0009);
        rd(8'h04, 32'h0000_0002);
        wr(8'h00, ctl ^ 32'h0000_00C0);
        rd(8'h00, ctl);
        chk(32'(sclk), 32'(idle));
        wr(8'h60, 32'h0000_0000);
        n = 0;
        prv = sclk;
        while (ss_n !== 1'b0 && n < 10) begin
            @(posedge mclk_in);
            n++;
        end
        n = 0;
        while (ss_n === 1'b0 && cyc < 19000) begin
            @(posedge mclk_in);
            #1;
            if (sclk !== prv)
                n++;
            prv = sclk;
        end
        // Count plus one frames of sixteen edges each
        chk(32'(n), 32'h0000_0030 + (m << 4));
        chk(32'(sclk), 32'(idle));
        rd(8'h60, 32'h0000_00C3 ^ m);
        rd(8'h60, 32'h0000_00C3 ^ (m + 32'h0000_0001));
        rd(8'h60, 32'h0000_00C3 ^ (m + 32'h0000_0002));
        rd(8'h60, 32'h0000_0000);
        wr(8'h08, 32'h0000_0000);
    endtask

    initial begin
        repeat (20) @(posedge mclk_in);
        chk({30'h0, sclk, ss_n}, 32'h0000_0001);
        rst_b_in <= 1'b1;
        rd(8'h00, 32'h0000_0000);
        rd(8'h04, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'h0000_FFFF);
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, 32'h0000_03F0);
        for (int k = 0; k < 3; k++) begin
            wr(8'h00, 32'(k) << 4);
            rd(8'h00, 32'(k) << 4);
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, 32'(k) << 8);
            rd(8'h00, 32'(k) << 8);
        end
        // Idle level set but format not SPI: clock rests low
        wr(8'h00, 32'h0000_00D0);
        repeat (3) @(posedge mclk_in);
        chk(32'(sclk), 32'h0000_0000);
        // Idle write of the transmit word puts its top bit on the line
        wr(8'h60, 32'h0000_0080);
        #1 chk(32'(txd), 32'h0000_0001);
        wr(8'h60, 32'h0000_0000);
        #1 chk(32'(txd), 32'h0000_0000);
        for (int k = 0; k < 4; k++)
            xfer(k[1], k[0], spf_pkg::DIR_RX);
        xfer(1'b0, 1'b1, spf_pkg::DIR_MEMRD);
        wrap_up();
    end
endmodule
